// [host_uart_flow_and_mode_control_bench.sv]
/*
 * Self-checking bench: module end and host end joined by the interface.
 * Assumes the package's fixed bit time; the run spans a few dozen frames.
 */
`timescale 1ns/10ps
`default_nettype none
module host_uart_flow_and_mode_control_bench;
    localparam int FRAME = hufc_pkg::BIT_CYCLES * 10;
    logic clk;
    logic resetn;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ready;
    logic send_break;
    logic rx_ready;
    logic rx_valid;
    logic [7:0] rx_data;
    logic up_valid;
    logic [7:0] up_data;
    logic up_ready;
    logic dn_valid;
    logic [7:0] dn_data;
    logic dn_ready;
    logic [1:0] link_count;
    logic link_event;
    logic transparent;
    int miscompares;
    int checks_done;

    hufc_if hufc_if_inst();
    hufc_dev hufc_dev_inst (.clk(clk), .resetn(resetn), .link(hufc_if_inst.dev),
        .up_valid(up_valid), .up_data(up_data), .up_ready(up_ready), .dn_valid(dn_valid),
        .dn_data(dn_data), .dn_ready(dn_ready), .link_count(link_count),
        .link_event(link_event), .transparent(transparent));
    hufc_host hufc_host_inst (.clk(clk), .resetn(resetn), .link(hufc_if_inst.host),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
        .send_break(send_break), .rx_ready(rx_ready), .rx_valid(rx_valid),
        .rx_data(rx_data));
    hufc_link_props hufc_link_props_inst (.clk(clk), .resetn(resetn),
        .dev_tx(hufc_if_inst.dev_tx), .host_tx(hufc_if_inst.host_tx),
        .dev_rts(hufc_if_inst.dev_rts), .host_rts(hufc_if_inst.host_rts));

    // Free-running 125 MHz clock.
    always #4 clk = ~clk;

    // ********************************
    // Shared tasks
    // ********************************
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp1(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    // A hung handshake ends the run; three frames is beyond any legal wait.
    task automatic wait_hs(ref logic v, ref logic r, input string what);
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (!(v === 1'b1 && r === 1'b1) && n < 3 * FRAME);
        if (n >= 3 * FRAME)
        begin
            miscompares++;
            $display("FAIL %s expected handshake seen timeout", what);
            close_out();
        end
    endtask

    // One host byte; valid drops for a cycle between bytes.
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk);
        #1;
        tx_valid = 1'b1;
        tx_data = b;
        wait_hs(tx_valid, tx_ready, "host tx");
        #1;
        tx_valid = 1'b0;
    endtask

    // ********************************
    // Scenarios
    // ********************************
    task automatic test_reset();
        repeat (8) @(posedge clk);
        #1;
        cmp1("module line idle", 1'b1, hufc_if_inst.dev_tx);
        cmp1("host line idle", 1'b1, hufc_if_inst.host_tx);
        cmp1("module rts ready", 1'b0, hufc_if_inst.dev_rts);
        cmp1("host cts ready", 1'b0, hufc_if_inst.host_rts);
        cmp1("command mode", 1'b0, transparent);
        $display("test_reset done");
    endtask

    // Indication raised while a send-data request comes in; the host stalls
    // its receive side and the radio side stalls the payload.
    task automatic test_events();
        logic [7:0] req[5];
        logic [7:0] evt[10];
        req = '{hufc_pkg::PKT_START, hufc_pkg::PKT_REQ, hufc_pkg::OP_SEND_DATA, 8'ha5,
            hufc_pkg::PKT_END};
        evt = '{hufc_pkg::PKT_START, hufc_pkg::PKT_IND, hufc_pkg::OP_INCOMING, 8'h01,
            hufc_pkg::PKT_END, hufc_pkg::PKT_START, hufc_pkg::PKT_CFM,
            hufc_pkg::OP_SEND_DATA, hufc_pkg::ST_OK, hufc_pkg::PKT_END};
        fork
            begin
                foreach (req[i]) send_byte(req[i]);
                wait_hs(up_valid, up_valid, "payload");
                repeat (5) @(posedge clk);
                #1;
                cmp1("payload held", 1'b1, up_valid);
                up_ready = 1'b1;
                wait_hs(up_valid, up_ready, "payload take");
                cmp8("payload", 8'ha5, up_data);
                #1;
                up_ready = 1'b0;
            end
            begin
                @(posedge clk);
                #1;
                link_event = 1'b1;
                @(posedge clk);
                #1;
                link_event = 1'b0;
                repeat (FRAME + FRAME / 2) @(posedge clk);
                #1;
                cmp1("host byte held", 1'b1, rx_valid);
                rx_ready = 1'b1;
                foreach (evt[i])
                begin
                    wait_hs(rx_valid, rx_ready, "event byte");
                    cmp8("event byte", evt[i], rx_data);
                end
            end
        join
        #1;
        cmp1("module rts ready", 1'b0, hufc_if_inst.dev_rts);
        cmp1("still command mode", 1'b0, transparent);
        $display("test_events done");
    endtask

    // Enter raw mode, pass one byte each way, then leave it by a break.
    task automatic test_transparent();
        logic [7:0] req[4];
        logic [7:0] cfm[5];
        req = '{hufc_pkg::PKT_START, hufc_pkg::PKT_REQ, hufc_pkg::OP_TRANSPARENT,
            hufc_pkg::PKT_END};
        cfm = '{hufc_pkg::PKT_START, hufc_pkg::PKT_CFM, hufc_pkg::OP_TRANSPARENT,
            hufc_pkg::ST_OK, hufc_pkg::PKT_END};
        foreach (req[i]) send_byte(req[i]);
        foreach (cfm[i])
        begin
            wait_hs(rx_valid, rx_ready, "mode confirm");
            cmp8("mode confirm", cfm[i], rx_data);
        end
        #1;
        cmp1("transparent entered", 1'b1, transparent);
        up_ready = 1'b1;
        send_byte(8'h5a);
        wait_hs(up_valid, up_ready, "raw up");
        cmp8("raw up", 8'h5a, up_data);
        #1;
        up_ready = 1'b0;
        dn_valid = 1'b1;
        dn_data = 8'h3c;
        wait_hs(dn_valid, dn_ready, "raw down");
        #1;
        dn_valid = 1'b0;
        wait_hs(rx_valid, rx_ready, "raw down byte");
        cmp8("raw down", 8'h3c, rx_data);
        #1;
        send_break = 1'b1;
        @(posedge clk);
        #1;
        send_break = 1'b0;
        repeat (3 * FRAME) @(posedge clk);
        #1;
        cmp1("break leaves transparent", 1'b0, transparent);
        $display("test_transparent done");
    endtask

    // Main sequence: reset for six cycles, then the scenarios.
    initial
    begin
        clk = 1'b0;
        resetn = 1'b0;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        send_break = 1'b0;
        rx_ready = 1'b0;
        up_ready = 1'b0;
        dn_valid = 1'b0;
        dn_data = 8'h00;
        link_count = 2'h1;
        link_event = 1'b0;
        miscompares = 0;
        checks_done = 0;
        repeat (6) @(posedge clk);
        #1;
        resetn = 1'b1;
        test_reset();
        test_events();
        test_transparent();
        close_out();
    end
endmodule
`default_nettype wire

// [hufc_dev.sv]
/*
 * Module end of the host UART link: receiver with break detect, transmitter
 * gated by CTS, command parser, transparent mode and a two-entry buffer
 * toward the radio side.
 * Assumes the interface joins it to the host end on the same clock; the
 * radio side is a plain valid/ready byte stream with a link-count input.
 */
`timescale 1ns/10ps
`default_nettype none
module hufc_dev
#(
    parameter int unsigned BREAK_CYCLES = hufc_pkg::BREAK_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    hufc_if.dev link,
    output logic up_valid,
    output logic [7:0] up_data,
    input wire logic up_ready,
    input wire logic dn_valid,
    input wire logic [7:0] dn_data,
    output logic dn_ready,
    input wire logic [1:0] link_count,
    input wire logic link_event,
    output logic transparent
);
    localparam int unsigned BC = hufc_pkg::BIT_CYCLES;

    // ************************************************************
    // Line synchronisers, receiver and break detect.
    // ************************************************************
    logic [1:0] rx_sync_q;
    logic [1:0] cts_sync_q;
    logic [8:0] rsh_q;
    logic [3:0] rbit_q;
    logic [15:0] rcnt_q;
    logic rbusy_q;
    logic rx_stb_q;
    logic [7:0] rx_byte_q;
    logic [31:0] low_q;
    logic brk_q;

    // Two flops on each incoming pin before any logic looks at it.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_sync_q <= 2'h3;
            cts_sync_q <= 2'h3;
        end
        else
        begin
            rx_sync_q <= {rx_sync_q[0], link.host_tx};
            cts_sync_q <= {cts_sync_q[0], link.host_rts};
        end
    end

    // Receiver samples mid-bit and drops frames whose stop bit is low.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsh_q <= 9'h0;
            rbit_q <= 4'h0;
            rcnt_q <= 16'h0;
            rbusy_q <= 1'b0;
            rx_stb_q <= 1'b0;
            rx_byte_q <= 8'h0;
        end
        else
        begin
            rx_stb_q <= 1'b0;
            if (!rbusy_q)
            begin
                if (!rx_sync_q[1] && !brk_q)
                begin
                    rbusy_q <= 1'b1;
                    rcnt_q <= 16'(BC + BC / 2);
                    rbit_q <= 4'h9;
                end
            end
            else if (rcnt_q != 16'h0)
            begin
                rcnt_q <= rcnt_q - 16'h1;
            end
            else
            begin
                rsh_q <= {rx_sync_q[1], rsh_q[8:1]};
                rcnt_q <= 16'(BC - 1);
                rbit_q <= rbit_q - 4'h1;
                if (rbit_q == 4'h1)
                begin
                    rbusy_q <= 1'b0;
                    rx_stb_q <= rx_sync_q[1];
                    rx_byte_q <= rsh_q[8:1];
                end
            end
        end
    end

    // Count low cycles; break holds until the line returns high.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            low_q <= 32'h0;
            brk_q <= 1'b0;
        end
        else if (rx_sync_q[1])
        begin
            low_q <= 32'h0;
            brk_q <= 1'b0;
        end
        else if (low_q >= 32'(BREAK_CYCLES))
        begin
            brk_q <= 1'b1;
        end
        else
        begin
            low_q <= low_q + 32'h1;
        end
    end

    // ************************************************************
    // Two-entry buffer toward the radio side.
    // ************************************************************
    logic [7:0] buf_mem[hufc_pkg::BUF_DEPTH];
    logic buf_wp_q;
    logic buf_rp_q;
    logic [1:0] buf_n_q;
    logic buf_push;
    logic [7:0] buf_in;
    logic buf_pop;

    assign buf_pop = up_valid && up_ready;

    // Pointer-based buffer; a radio stall fills it and raises RTS.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            buf_n_q <= 2'h0;
        end
        else
        begin
            if (buf_push)
            begin
                buf_wp_q <= !buf_wp_q;
            end
            if (buf_pop)
            begin
                buf_rp_q <= !buf_rp_q;
            end
            buf_n_q <= buf_n_q + {1'b0, buf_push} - {1'b0, buf_pop};
        end
    end

    always_ff @(posedge clk)
    begin
        if (buf_push)
        begin
            buf_mem[buf_wp_q] <= buf_in;
        end
    end

    // Outputs registered; valid is taken from the next fill count, so it follows the count in the same cycle.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            up_valid <= 1'b0;
            up_data <= 8'h0;
        end
        else
        begin
            up_valid <= (buf_n_q - {1'b0, buf_pop} + {1'b0, buf_push}) != 2'h0;
            up_data <= (buf_pop || buf_n_q == 2'h0) ?
                (buf_n_q == 2'h2 ? buf_mem[!buf_rp_q] : buf_in) : buf_mem[buf_rp_q];
        end
    end

    // ************************************************************
    // Command parser and mode control.
    // ************************************************************
    typedef enum logic [2:0]
    {
        HUFC_P_IDLE = 3'b000,
        HUFC_P_TYPE = 3'b001,
        HUFC_P_OP = 3'b010,
        HUFC_P_DATA = 3'b011,
        HUFC_P_END = 3'b100
    } hufc_parse_type;

    hufc_parse_type pst_q;
    logic [7:0] op_q;
    logic trans_q;
    logic cfm_req_q;
    logic [7:0] cfm_op_q;
    logic [7:0] cfm_st_q;
    logic ind_req_q;
    logic raw_ok;
    logic cfm_clr;
    logic ind_clr;

    // The closing byte ends the payload and is never passed on as data.
    assign raw_ok = pst_q == HUFC_P_DATA && op_q == hufc_pkg::OP_SEND_DATA &&
        rx_byte_q != hufc_pkg::PKT_END;
    // Transparent bytes bypass the parser entirely.
    assign buf_push = rx_stb_q && (trans_q || raw_ok) && buf_n_q != 2'h2;
    assign buf_in = rx_byte_q;

    // Package format: start, type, opcode, payload bytes, end.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pst_q <= HUFC_P_IDLE;
            op_q <= 8'h0;
        end
        else if (rx_stb_q && !trans_q)
        begin
            case (pst_q)
                HUFC_P_IDLE: pst_q <= rx_byte_q == hufc_pkg::PKT_START ? HUFC_P_TYPE : HUFC_P_IDLE;
                HUFC_P_TYPE: pst_q <= rx_byte_q == hufc_pkg::PKT_REQ ? HUFC_P_OP : HUFC_P_IDLE;
                HUFC_P_OP:
                begin
                    op_q <= rx_byte_q;
                    pst_q <= rx_byte_q == hufc_pkg::OP_SEND_DATA ? HUFC_P_DATA : HUFC_P_END;
                end
                HUFC_P_DATA: pst_q <= rx_byte_q == hufc_pkg::PKT_END ? HUFC_P_IDLE : HUFC_P_DATA;
                HUFC_P_END: pst_q <= HUFC_P_IDLE;
                default: pst_q <= HUFC_P_IDLE;
            endcase
        end
    end

    // A finished request queues a confirm; set wins over the send's clear.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            trans_q <= 1'b0;
            cfm_req_q <= 1'b0;
            cfm_op_q <= 8'h0;
            cfm_st_q <= 8'h0;
            ind_req_q <= 1'b0;
        end
        else
        begin
            if (cfm_clr)
            begin
                cfm_req_q <= 1'b0;
            end
            if (ind_clr)
            begin
                ind_req_q <= 1'b0;
            end
            if (link_event)
            begin
                ind_req_q <= 1'b1;
            end
            if (brk_q)
            begin
                trans_q <= 1'b0;
            end
            else if (rx_stb_q && !trans_q && rx_byte_q == hufc_pkg::PKT_END &&
                (pst_q == HUFC_P_END || pst_q == HUFC_P_DATA))
            begin
                cfm_req_q <= 1'b1;
                cfm_op_q <= op_q;
                cfm_st_q <= hufc_pkg::ST_OK;
                if (op_q == hufc_pkg::OP_TRANSPARENT)
                begin
                    if (link_count == 2'h1)
                    begin
                        trans_q <= 1'b1;
                    end
                    else
                    begin
                        cfm_st_q <= hufc_pkg::ST_REFUSED;
                    end
                end
            end
        end
    end

    // ************************************************************
    // Transmitter toward the host.
    // ************************************************************
    logic [3:0] tsel_q;
    logic [9:0] tsh_q;
    logic [3:0] tbit_q;
    logic [15:0] tcnt_q;
    logic tline_q;
    logic [7:0] tbyte;
    logic ev_ind_q;

    // Event byte sequence: start, type, opcode, status (link count for an indication), end.
    always_comb
    begin
        case (tsel_q)
            4'h1: tbyte = hufc_pkg::PKT_START;
            4'h2: tbyte = ev_ind_q ? hufc_pkg::PKT_IND : hufc_pkg::PKT_CFM;
            4'h3: tbyte = ev_ind_q ? hufc_pkg::OP_INCOMING : cfm_op_q;
            4'h4: tbyte = ev_ind_q ? {6'h0, link_count} : cfm_st_q;
            4'h5: tbyte = hufc_pkg::PKT_END;
            default: tbyte = dn_data;
        endcase
    end

    // The confirm of the mode switch still goes out once raw mode is on.
    assign cfm_clr = tsel_q == 4'h0 && tbit_q == 4'h0 && tcnt_q == 16'h0 &&
        !cts_sync_q[1] && cfm_req_q;
    assign ind_clr = tsel_q == 4'h0 && tbit_q == 4'h0 && tcnt_q == 16'h0 &&
        !cts_sync_q[1] && !cfm_req_q && ind_req_q && !trans_q;

    // Between bytes CTS is re-checked, so a high CTS holds back the next byte; a byte already on the line finishes.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            tsel_q <= 4'h0;
            tsh_q <= 10'h3ff;
            tbit_q <= 4'h0;
            tcnt_q <= 16'h0;
            tline_q <= 1'b1;
            dn_ready <= 1'b0;
            ev_ind_q <= 1'b0;
        end
        else
        begin
            dn_ready <= 1'b0;
            if (tbit_q != 4'h0 || tcnt_q != 16'h0)
            begin
                if (tcnt_q != 16'h0)
                begin
                    tcnt_q <= tcnt_q - 16'h1;
                end
                else
                begin
                    tline_q <= tsh_q[0];
                    tsh_q <= {1'b1, tsh_q[9:1]};
                    tbit_q <= tbit_q - 4'h1;
                    tcnt_q <= 16'(BC - 1);
                end
            end
            else if (!cts_sync_q[1])
            begin
                if (tsel_q != 4'h0)
                begin
                    tsh_q <= {1'b1, tbyte, 1'b0};
                    tbit_q <= 4'(hufc_pkg::FRAME_BITS);
                    tsel_q <= tsel_q == 4'h5 ? 4'h0 : tsel_q + 4'h1;
                end
                else if (cfm_clr || ind_clr)
                begin
                    ev_ind_q <= ind_clr;
                    tsel_q <= 4'h1;
                end
                else if (trans_q && dn_valid && !dn_ready)
                begin
                    tsh_q <= {1'b1, dn_data, 1'b0};
                    tbit_q <= 4'(hufc_pkg::FRAME_BITS);
                    dn_ready <= 1'b1;
                end
            end
        end
    end

    logic link_rts_q;

    // RTS goes high once the buffer is full.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            transparent <= 1'b0;
            link_rts_q <= 1'b1;
        end
        else
        begin
            transparent <= trans_q;
            link_rts_q <= buf_n_q + {1'b0, buf_push} >= 2'h2;
        end
    end

    assign link.dev_rts = link_rts_q;
    assign link.dev_tx = tline_q;
endmodule
`default_nettype wire

// [hufc_host.sv]
/*
 * Host end: a simple UART with RTS/CTS that moves user bytes onto the line
 * and received bytes back out, and can send a break.
 * Assumes the interface joins it to the module end on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module hufc_host
(
    input wire logic clk,
    input wire logic resetn,
    hufc_if.host link,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    input wire logic send_break,
    input wire logic rx_ready,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    localparam int unsigned BC = hufc_pkg::BIT_CYCLES;
    localparam int unsigned KC = hufc_pkg::BREAK_CYCLES * 2;
    logic [1:0] rts_sync_q;
    logic [1:0] rx_sync_q;
    logic [9:0] sh_q;
    logic [3:0] nbit_q;
    logic [15:0] cnt_q;
    logic brk_q;
    logic line_q;
    logic [8:0] rsh_q;
    logic [3:0] rbit_q;
    logic [15:0] rcnt_q;
    logic rbusy_q;

    // Synchronise the crossed-in lines.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rts_sync_q <= 2'h3;
            rx_sync_q <= 2'h3;
        end
        else
        begin
            rts_sync_q <= {rts_sync_q[0], link.dev_rts};
            rx_sync_q <= {rx_sync_q[0], link.dev_tx};
        end
    end

    // Transmitter; a new byte starts only while the module shows RTS low.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sh_q <= 10'h3ff;
            nbit_q <= 4'h0;
            cnt_q <= 16'h0;
            brk_q <= 1'b0;
            line_q <= 1'b1;
            tx_ready <= 1'b0;
        end
        else if (brk_q)
        begin
            line_q <= 1'b0;
            cnt_q <= cnt_q - 16'h1;
            if (cnt_q == 16'h0)
            begin
                brk_q <= 1'b0;
                line_q <= 1'b1;
            end
        end
        else if (nbit_q != 4'h0)
        begin
            tx_ready <= 1'b0;
            if (cnt_q == 16'h0)
            begin
                line_q <= sh_q[0];
                sh_q <= {1'b1, sh_q[9:1]};
                nbit_q <= nbit_q - 4'h1;
                cnt_q <= 16'(BC - 1);
            end
            else
            begin
                cnt_q <= cnt_q - 16'h1;
            end
        end
        else if (cnt_q != 16'h0)
        begin
            cnt_q <= cnt_q - 16'h1; // Last bit still on the line.
        end
        else if (send_break)
        begin
            brk_q <= 1'b1;
            cnt_q <= 16'(KC);
            tx_ready <= 1'b0;
        end
        else
        begin
            tx_ready <= !rts_sync_q[1];
            if (tx_valid && tx_ready && !rts_sync_q[1])
            begin
                sh_q <= {1'b1, tx_data, 1'b0};
                nbit_q <= 4'(hufc_pkg::FRAME_BITS);
                tx_ready <= 1'b0;
            end
        end
    end

    // Receiver; CTS is held low whenever no byte is waiting.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsh_q <= 9'h0;
            rbit_q <= 4'h0;
            rcnt_q <= 16'h0;
            rbusy_q <= 1'b0;
            rx_valid <= 1'b0;
            rx_data <= 8'h0;
        end
        else
        begin
            if (rx_valid && rx_ready)
            begin
                rx_valid <= 1'b0;
            end
            if (!rbusy_q)
            begin
                if (!rx_sync_q[1])
                begin
                    rbusy_q <= 1'b1;
                    rcnt_q <= 16'(BC + BC / 2);
                    rbit_q <= 4'h9;
                end
            end
            else if (rcnt_q != 16'h0)
            begin
                rcnt_q <= rcnt_q - 16'h1;
            end
            else
            begin
                rsh_q <= {rx_sync_q[1], rsh_q[8:1]};
                rcnt_q <= 16'(BC - 1);
                rbit_q <= rbit_q - 4'h1;
                if (rbit_q == 4'h1)
                begin
                    rbusy_q <= 1'b0;
                    rx_valid <= 1'b1;
                    rx_data <= rsh_q[8:1];
                end
            end
        end
    end

    assign link.host_tx = line_q;
    assign link.host_rts = rx_valid;
endmodule
`default_nettype wire

// [hufc_if.sv]
/*
 * Null-modem UART wiring between the module end and the host end.
 * Assumes both ends run on one clock; TX/RX and RTS/CTS are crossed here.
 */
`timescale 1ns/10ps
`default_nettype none
interface hufc_if;
    logic dev_tx;
    logic host_tx;
    logic dev_rts;
    logic host_rts;
    modport dev (output dev_tx, input host_tx, output dev_rts, input host_rts);
    modport host (input dev_tx, output host_tx, input dev_rts, output host_rts);
endinterface
`default_nettype wire

// [hufc_link_props.sv]
/*
 * Line checker for the host UART link: framing, CTS gating and RTS use.
 * Assumes it watches the crossed wires of one interface on a single clock.
 */
`timescale 1ns/10ps
`default_nettype none
module hufc_link_props
#(
    parameter int unsigned BIT_CYCLES = hufc_pkg::BIT_CYCLES
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic dev_tx,
    input wire logic host_tx,
    input wire logic dev_rts,
    input wire logic host_rts
);
    localparam int unsigned FRAME = BIT_CYCLES * 10;
    localparam int unsigned STOP_MID = BIT_CYCLES * 9 + BIT_CYCLES / 2;
    // On the host line a low stop bit is only legal when the line stays low past the frame (break).
    localparam int unsigned BRK_TAIL = FRAME - STOP_MID + 1;
    logic d_last_q;
    logic d_busy_q;
    int unsigned d_pos_q;
    logic h_last_q;
    logic h_busy_q;
    int unsigned h_pos_q;
    logic d_start;
    logic h_start;

    // A start bit is a falling line outside a frame.
    assign d_start = !d_busy_q && d_last_q && !dev_tx;
    assign h_start = !h_busy_q && h_last_q && !host_tx;

    // Frame position counters; a break would end its frame low and is not tracked further.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            d_last_q <= 1'b1;
            d_busy_q <= 1'b0;
            d_pos_q <= 0;
        end
        else
        begin
            d_last_q <= dev_tx;
            d_busy_q <= d_start || (d_busy_q && d_pos_q != FRAME - 1);
            d_pos_q <= d_start ? 1 : d_pos_q + 1;
        end
    end

    // The same count for the host's line.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            h_last_q <= 1'b1;
            h_busy_q <= 1'b0;
            h_pos_q <= 0;
        end
        else
        begin
            h_last_q <= host_tx;
            h_busy_q <= h_start || (h_busy_q && h_pos_q != FRAME - 1);
            h_pos_q <= h_start ? 1 : h_pos_q + 1;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_dev_start_cts: assert property (d_start |-> !$past(host_rts, 4))
        else $error("Module began a character while CTS was high.");
    a_dev_stop_cts: assert property (host_rts [*8] |-> !d_start)
        else $error("Module kept sending after CTS went high.");
    a_dev_bit_stable: assert property (d_busy_q && d_pos_q % BIT_CYCLES != 0 |-> $stable(dev_tx))
        else $error("Module line changed inside a bit time.");
    a_host_bit_stable: assert property (h_busy_q && h_pos_q % BIT_CYCLES != 0 |-> $stable(host_tx))
        else $error("Host line changed inside a bit time.");
    a_dev_stop_high: assert property (d_busy_q && d_pos_q == STOP_MID |-> dev_tx)
        else $error("Module stop bit was not high.");
    a_host_stop_high: assert property (h_busy_q && h_pos_q == STOP_MID |-> host_tx or ##BRK_TAIL !host_tx)
        else $error("Host stop bit was not high.");
    a_rts_after_reset: assert property ($rose(resetn) |-> ##[1:8] !dev_rts)
        else $error("Module RTS did not show ready after reset.");
    a_host_start_rts: assert property (h_start |-> !$past(dev_rts, 4))
        else $error("Host began a character while module RTS was high.");
endmodule
`default_nettype wire

// [hufc_pkg.sv]
/*
 * Shared constants for the host UART link: frame timing, package framing
 * codes, status values and the two-entry buffer depth.
 * Assumes a single 125 MHz clock shared by both ends.
 */
package hufc_pkg;
    // Clock rate and serial bit time.
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned BAUD = 1000000;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD;
    // Bits in one character frame: start, eight data, stop.
    localparam int unsigned FRAME_BITS = 10;
    // A break is a low line held longer than one whole frame.
    localparam int unsigned BREAK_CYCLES = BIT_CYCLES * FRAME_BITS + 1;
    // Package framing bytes.
    localparam logic [7:0] PKT_START = 8'h02;
    localparam logic [7:0] PKT_REQ = 8'h52;
    localparam logic [7:0] PKT_CFM = 8'h43;
    localparam logic [7:0] PKT_IND = 8'h69;
    localparam logic [7:0] PKT_END = 8'h03;
    // Opcodes.
    localparam logic [7:0] OP_SEND_DATA = 8'h0f;
    localparam logic [7:0] OP_TRANSPARENT = 8'h11;
    localparam logic [7:0] OP_INCOMING = 8'h0e;
    // Status codes.
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_REFUSED = 8'h01;
    localparam int unsigned BUF_DEPTH = 2;
endpackage
